// File: hdl/ddr3_ca_front.sv
// DDR3 command, address and clock-enable input front end (device side)
// How it works
// - PRECHARGE: A10 low one bank, high all
// - OTF enabled: A12 high BL8, low BC4
// - Address is row on ACTIVATE, column otherwise
// - LOAD MODE takes address as op-code
// - Bank inputs pick target of bank commands
// - LOAD MODE bank inputs pick MR0 to MR3
// - All inputs sampled on rising clock
// - Registered CKE gates internal clocks
// - CKE low: precharge, active power-down, self refresh
// - CKE synchronous for power-down and SR entry
// - Self refresh exit CKE treated as asynchronous and synchronised
// - Power-down ignores command and address
// - Self refresh ignores all but CKE
// - Chip select high masks every command
// - RAS, CAS, WE with CS form command
module ddr3_ca_front
  import ddr3_ca_pkg::*;
#(
  parameter int NUM_BANKS_P = NUM_BANKS
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ddr3_ca_pkg::ca_pins_t  pins,
  input  wire logic                   cke,
  output logic                        cmd_valid_reg,
  output ddr3_ca_pkg::cmd_info_t      cmd_reg,
  output ddr3_ca_pkg::pwr_t           state_reg,
  output logic                        core_clk_en_reg,
  output logic [1:0]                  mr0_bl_reg,
  output logic [NUM_BANKS_P-1:0]      bank_open
);
  import ddr3_ca_pkg::*;

  cmd_t code;
  pwr_t state_next;
  logic cke_q_reg;
  logic cke_s1_reg;
  logic cke_s2_reg;
  logic cke_s3_reg;
  logic sr_low_seen_reg;
  logic any_open;
  logic sr_entry;
  logic pd_entry;
  logic sr_exit;
  logic exec;

  // Command decode from the levels seen at this rising edge
  always_comb begin
    if (pins.cs_n) begin
      code = CMD_DESEL;
    end else begin
      unique case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h0:    code = CMD_MRS;
        3'h1:    code = CMD_REF;
        3'h2:    code = CMD_PRE;
        3'h3:    code = CMD_ACT;
        3'h4:    code = CMD_WRITE;
        3'h5:    code = CMD_READ;
        3'h6:    code = CMD_ZQ;
        default: code = CMD_NOP;
      endcase
    end
  end

  assign any_open = |bank_open;
  // CKE falling edge is only seen on a clock edge
  assign sr_entry = state_reg == ST_ACTIVE && cke_q_reg && !cke
                    && code == CMD_REF && !any_open;
  assign pd_entry = state_reg == ST_ACTIVE && cke_q_reg && !cke
                    && !sr_entry;
  assign sr_exit  = state_reg == ST_SREF && sr_low_seen_reg
                    && cke_s2_reg && cke_s3_reg;
  // Commands only while awake and CKE held high
  assign exec = state_reg == ST_ACTIVE && cke_q_reg && cke
                && code != CMD_DESEL && code != CMD_NOP;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ACTIVE: begin
        if (sr_entry) begin
          state_next = ST_SREF;
        end else if (pd_entry) begin
          state_next = any_open ? ST_APD : ST_PPD;
        end
      end
      ST_PPD, ST_APD: begin
        if (cke) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_SREF: begin
        if (sr_exit) begin
          state_next = ST_ACTIVE;
        end
      end
      default: state_next = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg       <= ST_ACTIVE;
      core_clk_en_reg <= 1'b1;
    end else begin
      state_reg       <= state_next;
      core_clk_en_reg <= state_next == ST_ACTIVE;
    end
  end

  // Clock-domain CKE; frozen in self refresh since the clock is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_q_reg <= 1'b0;
    end else if (sr_exit) begin
      cke_q_reg <= 1'b1;
    end else if (state_reg != ST_SREF) begin
      cke_q_reg <= cke;
    end
  end

  // CKE exit path treated as asynchronous, so it is synchronised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_s1_reg <= 1'b0;
      cke_s2_reg <= 1'b0;
      cke_s3_reg <= 1'b0;
    end else begin
      cke_s1_reg <= cke;
      cke_s2_reg <= cke_s1_reg;
      cke_s3_reg <= cke_s2_reg;
    end
  end

  // Stale high from before entry must not count as an exit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_low_seen_reg <= 1'b0;
    end else if (state_reg != ST_SREF) begin
      sr_low_seen_reg <= 1'b0;
    end else if (!cke_s2_reg && !cke_s3_reg) begin
      sr_low_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr0_bl_reg <= MR0_BL_RESET;
    end else if (exec && code == CMD_MRS
                 && pins.ba[MR_SEL_W-1:0] == MR0_SEL) begin
      mr0_bl_reg <= pins.addr[BL_LSB +: 2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= exec;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_reg <= '0;
    end else if (exec) begin
      cmd_reg.cmd      <= code;
      cmd_reg.bank     <= pins.ba;
      cmd_reg.row      <= pins.addr;
      cmd_reg.col      <= pins.addr[COL_W-1:0];
      cmd_reg.auto_pre <= (code == CMD_READ || code == CMD_WRITE)
                          && pins.addr[A_AP];
      cmd_reg.pre_all  <= code == CMD_PRE && pins.addr[A_AP];
      // A12 counts only when MR0 selects on-the-fly
      cmd_reg.bc4      <= (code == CMD_READ || code == CMD_WRITE)
                          && (mr0_bl_reg == BL_OTF ? !pins.addr[A_BC]
                              : mr0_bl_reg == BL_FIXED4);
      cmd_reg.mr_sel   <= pins.ba[MR_SEL_W-1:0];
      cmd_reg.opcode   <= pins.addr;
    end
  end

  for (genvar i = 0; i < NUM_BANKS_P; i++) begin : g_bank
    bank_row_state #(
      .BANK_W_P (BANK_W),
      .IDX      (BANK_W'(i))
    ) u_bank (
      .clk      (clk),
      .rst      (rst),
      .act      (exec && code == CMD_ACT),
      .pre      (exec && code == CMD_PRE),
      .pre_all  (pins.addr[A_AP]),
      .ba       (pins.ba),
      .open_reg (bank_open[i])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_pre_all_flag: assert property (
    exec && code == CMD_PRE |=> cmd_reg.pre_all == $past(pins.addr[A_AP]))
    else $error("precharge-all flag does not follow A10");
  chk_pre_all_close: assert property (
    cmd_valid_reg && cmd_reg.cmd == CMD_PRE && cmd_reg.pre_all
      |-> bank_open == '0)
    else $error("precharge all left a bank open");
  chk_otf_chop: assert property (
    exec && code == CMD_READ && mr0_bl_reg == BL_OTF
      |=> cmd_reg.bc4 == !$past(pins.addr[A_BC]))
    else $error("on-the-fly chop does not follow A12");
  chk_fixed_burst: assert property (
    exec && code == CMD_WRITE && mr0_bl_reg == BL_FIXED8 |=> !cmd_reg.bc4)
    else $error("fixed BL8 write was chopped");
  chk_act_row_bank: assert property (
    exec && code == CMD_ACT |=> cmd_reg.row == $past(pins.addr)
      && bank_open[$past(pins.ba)])
    else $error("activate row or bank not taken");
  chk_mrs_opcode: assert property (
    exec && code == CMD_MRS |=> cmd_reg.cmd == CMD_MRS
      && cmd_reg.opcode == $past(pins.addr)
      && cmd_reg.mr_sel == $past(pins.ba[MR_SEL_W-1:0]))
    else $error("mode register load mis-captured");
  chk_cs_mask: assert property (
    pins.cs_n |=> !cmd_valid_reg)
    else $error("command accepted with chip select high");
  chk_pd_ignore: assert property (
    state_reg != ST_ACTIVE |=> !cmd_valid_reg)
    else $error("command accepted while powered down");
  chk_pd_kind: assert property (
    pd_entry |=> state_reg == (($past(any_open)) ? ST_APD : ST_PPD))
    else $error("wrong power-down kind");
  chk_sr_exit: assert property (
    state_reg == ST_SREF && !cke ##1 cke [*4]
      |-> ##[0:1] state_reg == ST_ACTIVE)
    else $error("self refresh exit not detected");
  chk_clk_gate: assert property (
    pd_entry || sr_entry |=> !core_clk_en_reg [*2])
    else $error("internal clock not gated on CKE low");

  cov_sref: cover property (sr_entry ##[1:20] sr_exit);
  cov_apd: cover property (pd_entry && any_open);
  cov_bc4_read: cover property (
    exec && code == CMD_READ && mr0_bl_reg == BL_OTF && !pins.addr[A_BC]);
  cov_pre_all: cover property (exec && code == CMD_PRE && pins.addr[A_AP]);
endmodule // ddr3_ca_front

// File: hdl/ddr3_ca_pkg.sv
// Shared types and constants for the DDR3 command/address input front end
package ddr3_ca_pkg;
  localparam int ADDR_W    = 14;
  localparam int BANK_W    = 3;
  localparam int NUM_BANKS = 8;
  localparam int COL_W     = 10;
  localparam int MR_SEL_W  = 2;

  // Burst length field of MR0, bits [1:0]
  localparam int       BL_LSB      = 0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] MR0_BL_RESET = 2'h0;
  localparam logic [1:0] MR0_SEL   = 2'h0;

  // Address bit positions with a special role
  localparam int A_AP = 10;
  localparam int A_BC = 12;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_DESEL = 4'h1,
    CMD_ACT   = 4'h2,
    CMD_READ  = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_PRE   = 4'h5,
    CMD_REF   = 4'h6,
    CMD_MRS   = 4'h7,
    CMD_ZQ    = 4'h8
  } cmd_t;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_PPD    = 4'h2,
    ST_APD    = 4'h4,
    ST_SREF   = 4'h8
  } pwr_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } ca_pins_t;

  typedef struct packed {
    cmd_t                cmd;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   row;
    logic [COL_W-1:0]    col;
    logic                auto_pre;
    logic                pre_all;
    logic                bc4;
    logic [MR_SEL_W-1:0] mr_sel;
    logic [ADDR_W-1:0]   opcode;
  } cmd_info_t;
endpackage

// File: hdl/bank_row_state.sv
// Open/closed row state of one bank
module bank_row_state
  import ddr3_ca_pkg::*;
#(
  parameter int                  BANK_W_P = BANK_W,
  parameter logic [BANK_W_P-1:0] IDX      = 3'h0
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              act,
  input  wire logic              pre,
  input  wire logic              pre_all,
  input  wire logic [BANK_W_P-1:0] ba,
  output logic                   open_reg
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open_reg <= 1'b0;
    end else if (act && ba == IDX) begin
      open_reg <= 1'b1;
    end else if (pre && (pre_all || ba == IDX)) begin
      open_reg <= 1'b0;
    end
  end
endmodule // bank_row_state

// File: verification/ddr3_ctrl_model.sv
// Controller-side model driving command, address and clock enable
module ddr3_ctrl_model (
  input  wire logic             clk,
  output ddr3_ca_pkg::ca_pins_t pins,
  output logic                  cke
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddr3_ca_pkg::*;

  initial begin
    pins = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
             ba: 3'h0, addr: 14'h0};
    cke  = 1'b1;
  end

  // Falling-edge launch keeps levels settled at the rising edge
  task automatic cmd(input logic [3:0] c, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a, input logic k);
    @(negedge clk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
    pins.ba   = b;
    pins.addr = a;
    cke       = k;
    @(negedge clk);
    // Deselected lines must not keep the last value
    pins.cs_n = 1'b1;
    pins.ba   = ~b;
    pins.addr = ~a;
  endtask
endmodule // ddr3_ctrl_model

// File: verification/tb_ddr3_cmd_addr_cke_inputs.sv
// Self-checking bench for the command/address/clock-enable front end
module tb_ddr3_cmd_addr_cke_inputs;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr3_ca_pkg::*;

  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_ZQ  = 4'h6;
  localparam logic [3:0] C_NOP = 4'hF;

  logic                 clk = 1'b0;
  logic                 rst;
  ca_pins_t             pins;
  logic                 cke;
  logic                 cmd_valid_reg;
  cmd_info_t            cmd_reg;
  pwr_t                 state_reg;
  logic                 core_clk_en_reg;
  logic [1:0]           mr0_bl_reg;
  logic [NUM_BANKS-1:0] bank_open;
  int                   bad_count = 0;
  int                   n_compared = 0;
  int                   cycles = 0;

  always #10 clk = ~clk;

  ddr3_ctrl_model ctrl_u (.clk(clk), .pins(pins), .cke(cke));

  ddr3_ca_front #(.NUM_BANKS_P(NUM_BANKS)) dut_u (
    .clk(clk), .rst(rst), .pins(pins), .cke(cke),
    .cmd_valid_reg(cmd_valid_reg), .cmd_reg(cmd_reg),
    .state_reg(state_reg), .core_clk_en_reg(core_clk_en_reg),
    .mr0_bl_reg(mr0_bl_reg), .bank_open(bank_open));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic t_burst();
    ctrl_u.cmd(C_MRS, 3'h0, 14'h0001, 1'b1);
    chk({cmd_reg.opcode, cmd_reg.mr_sel, mr0_bl_reg},
        {14'h0001, 2'h0, BL_OTF});
    ctrl_u.cmd(C_ACT, 3'h2, 14'h2ABC, 1'b1);
    chk({cmd_reg.row, bank_open}, {14'h2ABC, 8'h04});
    ctrl_u.cmd(C_RD, 3'h2, 14'h0555, 1'b1);
    chk({cmd_reg.bank, cmd_reg.bc4, cmd_reg.auto_pre, cmd_reg.col},
        15'h2D55);
    ctrl_u.cmd(C_WR, 3'h2, 14'h1003, 1'b1);
    chk({cmd_reg.cmd, cmd_reg.bc4, cmd_reg.auto_pre},
        {CMD_WRITE, 2'b00});
    ctrl_u.cmd(C_MRS, 3'h3, 14'h0002, 1'b1);
    chk({cmd_reg.mr_sel, mr0_bl_reg}, {2'h3, BL_OTF});
    ctrl_u.cmd(C_MRS, 3'h0, 14'h0000, 1'b1);
    ctrl_u.cmd(C_RD, 3'h2, 14'h0000, 1'b1);
    chk(cmd_reg.bc4, 1'b0);
    ctrl_u.cmd(C_MRS, 3'h0, 14'h0002, 1'b1);
    ctrl_u.cmd(C_WR, 3'h2, 14'h1000, 1'b1);
    chk(cmd_reg.bc4, 1'b1);
    $display("test burst done");
  endtask

  task automatic t_pre();
    ctrl_u.cmd(C_ACT, 3'h5, 14'h0011, 1'b1);
    ctrl_u.cmd(C_PRE, 3'h2, 14'h0000, 1'b1);
    chk({cmd_valid_reg, cmd_reg.pre_all, bank_open}, 10'h220);
    ctrl_u.cmd(C_PRE, 3'h2, 14'h0400, 1'b1);
    chk({cmd_reg.pre_all, bank_open}, 9'h100);
    // Command code with chip select high must be masked
    ctrl_u.cmd(4'hB, 3'h1, 14'h0022, 1'b1);
    chk({cmd_valid_reg, bank_open}, 9'h000);
    // Plain refresh and calibration with CKE held high are executed
    ctrl_u.cmd(C_REF, 3'h0, 14'h0000, 1'b1);
    chk({cmd_valid_reg, cmd_reg.cmd, state_reg},
        {1'b1, CMD_REF, ST_ACTIVE});
    ctrl_u.cmd(C_ZQ, 3'h0, 14'h0400, 1'b1);
    chk({cmd_valid_reg, cmd_reg.cmd}, {1'b1, CMD_ZQ});
    $display("test precharge done");
  endtask

  task automatic t_pd();
    ctrl_u.cmd(C_ACT, 3'h0, 14'h0033, 1'b1);
    ctrl_u.cmd(C_NOP, 3'h0, 14'h0000, 1'b0);
    chk({state_reg, core_clk_en_reg}, {ST_APD, 1'b0});
    ctrl_u.cmd(C_ACT, 3'h3, 14'h0044, 1'b0);
    chk({cmd_valid_reg, bank_open}, 9'h001);
    ctrl_u.cmd(C_NOP, 3'h0, 14'h0000, 1'b1);
    chk({state_reg, core_clk_en_reg}, {ST_ACTIVE, 1'b1});
    ctrl_u.cmd(C_PRE, 3'h0, 14'h0400, 1'b1);
    ctrl_u.cmd(C_NOP, 3'h0, 14'h0000, 1'b0);
    chk(state_reg, ST_PPD);
    ctrl_u.cmd(C_NOP, 3'h0, 14'h0000, 1'b1);
    chk(state_reg, ST_ACTIVE);
    $display("test power-down done");
  endtask

  task automatic t_sref();
    int n;
    ctrl_u.cmd(C_REF, 3'h0, 14'h0000, 1'b0);
    chk({cmd_valid_reg, state_reg}, {1'b0, ST_SREF});
    repeat (3) ctrl_u.cmd(C_ACT, 3'h6, 14'h0055, 1'b0);
    chk({state_reg, bank_open}, {ST_SREF, 8'h00});
    ctrl_u.cmd(C_NOP, 3'h0, 14'h0000, 1'b1);
    n = 0;
    while (state_reg !== ST_ACTIVE && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(state_reg, ST_ACTIVE);
    ctrl_u.cmd(C_ACT, 3'h7, 14'h0066, 1'b1);
    chk(bank_open, 8'h80);
    $display("test self refresh done");
  endtask

  // The whole sequence needs about 80 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_burst();
    t_pre();
    t_pd();
    t_sref();
    summarize();
  end
endmodule // tb_ddr3_cmd_addr_cke_inputs
